/* hdl/pdwl_lock.v */
/*
 Write lock for the peripheral disable registers and the lock bit of the
 configuration control register, with an optional one-way latch.
 Assumes the system bus decodes accesses into the strobes below and that
 the unlock sequence is tracked elsewhere and reported as a level.
 Assumes the device configuration word is steady while out of reset; a
 late change of the one-way option only ever tightens the lock.
*/
`include "pdwl_consts.vh"

module pdwl_lock #(
	parameter REG_COUNT = `PDWL_REG_COUNT,
	parameter REG_WIDTH = `PDWL_REG_WIDTH,
	parameter IDX_WIDTH = `PDWL_IDX_WIDTH,
	parameter CFG_WIDTH = `PDWL_CFG_WIDTH
) (
	// Clock and reset.
	input  wire                 i_core_clk,
	input  wire                 i_rstn,
	// Device configuration word 3 and unlock state.
	input  wire [CFG_WIDTH-1:0] i_device_config_word3,
	input  wire                 i_unlocked,
	// Configuration control register write.
	input  wire                 i_cfg_wr,
	input  wire [CFG_WIDTH-1:0] i_cfg_wdata,
	// Disable register access.
	input  wire                 i_pd_wr,
	input  wire                 i_pd_rd,
	input  wire [IDX_WIDTH-1:0] i_pd_idx,
	input  wire [REG_WIDTH-1:0] i_pd_wdata,
	// Answers.
	output reg                  o_ack,
	output reg  [REG_WIDTH-1:0] o_pd_rdata,
	output reg  [CFG_WIDTH-1:0] o_cfg_rdata,
	output reg                  o_disable_reg_lock,
	output reg                  o_one_way_latched,
	output reg                  o_unlock_allowed
);

	// Lock states: open, set by software, and held set by the one-way option.
	localparam [1:0] ST_OPEN    = 2'h0;
	localparam [1:0] ST_LOCKED  = 2'h1;
	localparam [1:0] ST_LATCHED = 2'h2;
	localparam [1:0] ST_RESET   = `PDWL_LOCK_RESET ? ST_LOCKED : ST_OPEN;

	reg  [1:0]           state_q;
	reg  [1:0]           state_d;
	reg                  lock_d;
	reg                  one_way_d;
	wire                 lock_now;
	wire                 latch_now;
	wire                 one_way_opt;
	wire                 unlock_ok;
	wire                 lock_wr;
	wire                 wr_lock_val;
	wire                 pd_wr_en;
	wire [REG_WIDTH-1:0] pd_rdata;

	// True in every state that blocks writes to the disable registers.
	function is_locked;
		input [1:0] st;
		begin
			is_locked = (st != ST_OPEN);
		end
	endfunction

	// True once the one-way option holds the lock.
	function is_latched;
		input [1:0] st;
		begin
			is_latched = (st == ST_LATCHED);
		end
	endfunction

	// Lock bit of a configuration control word.
	function lock_field;
		input [CFG_WIDTH-1:0] word;
		begin
			lock_field = word[`PDWL_LOCK_BIT];
		end
	endfunction

	// Configuration control word as read back, with the lock in its place.
	function [CFG_WIDTH-1:0] cfg_view;
		input lock;
		begin
			cfg_view = {CFG_WIDTH{1'h0}};
			cfg_view[`PDWL_LOCK_BIT] = lock;
		end
	endfunction

	assign lock_now = is_locked(state_q);
	assign latch_now = is_latched(state_q);
	assign one_way_opt = i_device_config_word3[`PDWL_ONE_WAY_BIT];
	// The unlock procedure is refused once the one-way latch holds.
	assign unlock_ok = i_unlocked && !latch_now;
	// Only an unlocked configuration write may move the lock.
	assign lock_wr = i_cfg_wr && unlock_ok;
	assign wr_lock_val = lock_field(i_cfg_wdata);
	// A write reaches storage only with the lock clear.
	assign pd_wr_en = i_pd_wr && !lock_now;

	// A set lock with the option programmed moves to the latched state at once,
	// so a clearing write in the same cycle cannot slip through.
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_OPEN: begin
				if (lock_wr && wr_lock_val) begin
					if (one_way_opt) begin
						state_d = ST_LATCHED;
					end else begin
						state_d = ST_LOCKED;
					end
				end
			end
			ST_LOCKED: begin
				if (one_way_opt) begin
					state_d = ST_LATCHED;
				end else if (lock_wr && !wr_lock_val) begin
					state_d = ST_OPEN;
				end
			end
			ST_LATCHED: begin
				state_d = ST_LATCHED;
			end
			default: begin
				// An unused code fails safe to the locked state.
				state_d = ST_LOCKED;
			end
		endcase
	end

	always @* begin
		lock_d = is_locked(state_d);
		one_way_d = is_latched(state_d);
	end

	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			state_q <= ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	pdwl_disable_regs #(
		.REG_COUNT (REG_COUNT),
		.REG_WIDTH (REG_WIDTH),
		.IDX_WIDTH (IDX_WIDTH)
	) u_regs (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_wr_en    (pd_wr_en),
		.i_wr_idx   (i_pd_idx),
		.i_wr_data  (i_pd_wdata),
		.i_rd_idx   (i_pd_idx),
		.o_rd_data  (pd_rdata)
	);

	// Every access is acknowledged, rejected or not, so the bus never sees a fault.
	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_ack <= 1'h0;
		end else begin
			o_ack <= i_pd_wr | i_pd_rd | i_cfg_wr;
		end
	end

	// Read data stands for one cycle after a read and is zero otherwise.
	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_pd_rdata <= {REG_WIDTH{1'h0}};
		end else if (i_pd_rd) begin
			o_pd_rdata <= pd_rdata;
		end else begin
			o_pd_rdata <= {REG_WIDTH{1'h0}};
		end
	end

	// Lock status shows the value after this edge's write.
	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_cfg_rdata <= {CFG_WIDTH{1'h0}};
		end else begin
			o_cfg_rdata <= cfg_view(lock_d);
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_disable_reg_lock <= 1'h0;
		end else begin
			o_disable_reg_lock <= lock_d;
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_one_way_latched <= 1'h0;
		end else begin
			o_one_way_latched <= one_way_d;
		end
	end

	// Unlocking is reported as refused from the very edge the latch takes hold.
	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_unlock_allowed <= 1'h0;
		end else begin
			o_unlock_allowed <= i_unlocked && !one_way_d;
		end
	end

endmodule

/* hdl/pdwl_consts.vh */
/*
 Constants for the peripheral disable write lock block.
 Assumes it is included by bare name from the design files.
*/
`ifndef PDWL_CONSTS_VH
`define PDWL_CONSTS_VH

`define PDWL_LOCK_BIT      12
`define PDWL_ONE_WAY_BIT   28
`define PDWL_CFG_WIDTH     32
`define PDWL_LOCK_RESET    1'h0
`define PDWL_REG_COUNT     7
`define PDWL_REG_WIDTH     32
`define PDWL_REG_RESET     32'h00000000
`define PDWL_IDX_WIDTH     3

`endif

/* hdl/pdwl_disable_regs.v */
/*
 Storage for the peripheral disable registers, one word per index below REG_COUNT.
 Assumes the caller has already decided whether a write may land.
*/
`include "pdwl_consts.vh"

module pdwl_disable_regs #(
	parameter REG_COUNT = `PDWL_REG_COUNT,
	parameter REG_WIDTH = `PDWL_REG_WIDTH,
	parameter IDX_WIDTH = `PDWL_IDX_WIDTH
) (
	// Clock and reset.
	input  wire                 i_core_clk,
	input  wire                 i_rstn,
	// Write port, already gated by the lock.
	input  wire                 i_wr_en,
	input  wire [IDX_WIDTH-1:0] i_wr_idx,
	input  wire [REG_WIDTH-1:0] i_wr_data,
	// Read port.
	input  wire [IDX_WIDTH-1:0] i_rd_idx,
	output wire [REG_WIDTH-1:0] o_rd_data
);

	reg [REG_WIDTH-1:0] regs_q [0:REG_COUNT-1];
	integer k;

	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			for (k = 0; k < REG_COUNT; k = k + 1) begin
				regs_q[k] <= `PDWL_REG_RESET;
			end
		end else if (i_wr_en && (i_wr_idx < REG_COUNT)) begin
			regs_q[i_wr_idx] <= i_wr_data;
		end
	end

	assign o_rd_data = (i_rd_idx < REG_COUNT) ? regs_q[i_rd_idx] : {REG_WIDTH{1'b0}};

endmodule

/* verification/pdwl_lock_chk.sv */
/* Checker for the disable register write lock.
 Assumes it is bound to pdwl_lock and sees only its ports. */
module pdwl_lock_chk (
	input logic i_core_clk, i_rstn, i_unlocked, i_cfg_wr, i_pd_wr, i_pd_rd, o_ack,
	input logic o_disable_reg_lock, o_one_way_latched, o_unlock_allowed,
	input logic [2:0] i_pd_idx,
	input logic [31:0] i_cfg_wdata, o_pd_rdata, o_cfg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	wire acc = i_cfg_wr | i_pd_wr | i_pd_rd;
	a_ack_pulse: assert property (acc |=> o_ack) else $error("ack");
	a_ack_idle: assert property (!acc |=> !o_ack) else $error("stray ack");
	a_cfg_view: assert property (o_cfg_rdata == {o_disable_reg_lock, 12'h0}) else $error("cfg");
	a_lock_set: assert property (i_cfg_wr && i_unlocked && i_cfg_wdata[12]
		|=> o_disable_reg_lock) else $error("set");
	a_lock_keep: assert property (i_cfg_wr && !i_unlocked
		|=> $stable(o_disable_reg_lock)) else $error("keep");
	a_one_way: assert property (o_one_way_latched
		|=> o_disable_reg_lock && o_one_way_latched) else $error("latch");
	a_unlock_off: assert property (o_one_way_latched |=> !o_unlock_allowed) else $error("ul");
	a_rd_idle: assert property (!(i_pd_rd && i_pd_idx < 3'h7) |=> o_pd_rdata == 32'h0) else $error("rd");
	c_lock: cover property (i_pd_wr && o_disable_reg_lock);
	c_latch: cover property ($rose(o_one_way_latched));
	c_refuse: cover property (i_cfg_wr && !i_unlocked);
endmodule
bind pdwl_lock pdwl_lock_chk u_pdwl_lock_chk (.*);

/* verification/tb_pdwl_lock.sv */
/* Bench for the disable register write lock.
 Drives every input at the falling edge. */
module tb_pdwl_lock;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_core_clk = 0, i_rstn = 0, i_unlocked = 0, i_cfg_wr = 0, i_pd_wr = 0, i_pd_rd = 0;
	logic o_ack, o_disable_reg_lock, o_one_way_latched, o_unlock_allowed;
	logic [2:0] i_pd_idx = 0;
	logic [31:0] i_device_config_word3 = 0, i_cfg_wdata = 0, i_pd_wdata = 0, o_pd_rdata, o_cfg_rdata;
	int miscompares = 0, checks = 0, cyc = 0;
	pdwl_lock u_pdwl_lock (.*);
	always #10 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) if (++cyc == 500) begin
		miscompares++;
		final_report();
	end
	task final_report;
		if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(string n, logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task acc(logic c, w, r, logic [2:0] x, logic [31:0] d);
		@(negedge i_core_clk);
		{i_cfg_wr, i_pd_wr, i_pd_rd, i_pd_idx, i_cfg_wdata, i_pd_wdata} = {c, w, r, x, d, d};
		@(negedge i_core_clk);
		{i_cfg_wr, i_pd_wr, i_pd_rd} = 3'h0;
		chk("ack", 32'h1, o_ack);
	endtask
	task rd(logic [2:0] x, logic [31:0] e);
		acc(0, 0, 1, x, 32'h0);
		chk("rdata", e, o_pd_rdata);
	endtask
	task lk(logic e);
		chk("lock", e, o_disable_reg_lock);
	endtask
	task rst;
		i_rstn = 0;
		repeat (10) @(negedge i_core_clk);
		i_rstn = 1;
	endtask
	task t_open;
		acc(0, 1, 0, 3'h3, 32'hA5);
		rd(3'h3, 32'hA5);
		rd(3'h7, 32'h0);
	endtask
	task t_lock;
		i_unlocked = 1;
		acc(1, 0, 0, 3'h0, 32'h1000);
		lk(1);
		chk("cfg", 32'h1000, o_cfg_rdata);
		acc(0, 1, 0, 3'h3, 32'h5A);
		rd(3'h3, 32'hA5);
	endtask
	task t_seq;
		i_unlocked = 0;
		acc(1, 0, 0, 3'h0, 32'h0);
		lk(1);
		i_unlocked = 1;
		acc(1, 0, 0, 3'h0, 32'h0);
		lk(0);
		chk("allow", 32'h1, o_unlock_allowed);
	endtask
	task t_oneway;
		i_device_config_word3 = 32'h10000000;
		acc(1, 0, 0, 3'h0, 32'h1000);
		acc(1, 0, 0, 3'h0, 32'h0);
		lk(1);
		chk("latched", 32'h1, o_one_way_latched);
		chk("allow", 32'h0, o_unlock_allowed);
		rst();
		lk(0);
		chk("latched", 32'h0, o_one_way_latched);
		acc(0, 1, 0, 3'h3, 32'h0F);
		rd(3'h3, 32'h0F);
	endtask
	initial begin
		rst();
		t_open();
		t_lock();
		t_seq();
		t_oneway();
		final_report();
	end
endmodule
